// [dv/npc_far_side.sv]
// far-side model: trap stack entries at the current trap level
`timescale 1ns/1ps
module npc_far_side
    import npc_pkg::*;
(
    // level
    input wire logic [NPC_TL_W-1:0] trap_level_i,
    // stack entries
    output logic [63:0] trap_pc_stack_o,
    output logic [63:0] trap_npc_stack_o,
    output logic [63:0] trap_state_stack_o
);
    // high pc bits set so the address mask has something to clear
    assign trap_pc_stack_o = 64'hC0DE_0000_8000_1000 + {53'h0, trap_level_i, 8'h00};
    assign trap_npc_stack_o = trap_pc_stack_o + 64'h0000_0000_0000_0004;
    assign trap_state_stack_o = {61'h0, trap_level_i} ^ 64'h0000_0000_0000_00A5;
endmodule

// [dv/test_npc_ctrl.sv]
// self-checking bench for the next pc and conditional move block
`timescale 1ns/1ps
module test_npc_ctrl
    import npc_pkg::*;
;
    typedef struct packed {logic [63:0] p; logic [63:0] n; logic w; logic [63:0] d;} npc_exp_t;
    logic clk = 1'b0, rst_n, valid, pv, am, lwe, mwe, twe, vd = 1'b0, h;
    logic sa, pe, fe, sr;
    npc_instr_t instr, ins;
    npc_ccs_t cc;
    logic [63:0] a, b, trap_base_register, pc, nx, ldat, mdat, tps, tns, tss, cp, cn, r1, r2, s, ea;
    logic [8:0] tdat, tt;
    logic [2:0] tl, rt;
    npc_exp_t exq[$];
    npc_exp_t e;
    int n_errors = 0, cmp_count = 0, seed = 66;
    npc_ctrl npc_ctrl_i (.clk_i(clk), .rst_n_i(rst_n), .valid_i(valid), .instr_i(instr),
        .first_source_reg_i(a), .second_source_reg_i(b), .move_source_i(b), .ccs_i(cc),
        .priv_i(pv), .address_mask_flag_i(am), .trap_base_register_i(trap_base_register),
        .trap_pc_stack_i(tps), .trap_npc_stack_i(tns), .trap_state_stack_i(tss),
        .pc_o(pc), .next_program_counter_o(nx), .slot_annulled_o(sa), .link_we_o(lwe),
        .link_idx_o(), .link_data_o(ldat), .move_we_o(mwe), .move_idx_o(), .move_data_o(mdat),
        .trap_level_o(tl), .trap_type_we_o(twe), .trap_type_idx_o(), .trap_type_data_o(tdat),
        .state_restore_o(sr), .restored_state_o(), .priv_exc_o(pe),
        .current_window_pointer_o(), .restorable_window_count_o(),
        .savable_window_count_o(), .fill_exc_o(fe));
    npc_far_side npc_far_side_i (.trap_level_i(tl), .trap_pc_stack_o(tps),
        .trap_npc_stack_o(tns), .trap_state_stack_o(tss));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic check(logic [63:0] got, logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic npc_instr_t mk(npc_op_t op, logic an, logic [2:0] cs, logic is, logic [4:0] rd);
        mk = '0;
        mk.op = op;
        mk.annul = an;
        mk.cc_sel = cs;
        mk.cond = 4'h8;
        mk.rtest = rt;
        mk.imm_sel = is;
        mk.disp = 30'h0000_0010;
        mk.signed_imm_13 = 13'h1FF8;
        mk.rd = rd;
    endfunction
    // one instruction per edge; expectation noted as it is issued
    task automatic send(npc_instr_t i, logic [63:0] x1, x2, logic p1, m1,
            logic [63:0] ep, en, logic ew, logic [63:0] ed);
        @(posedge clk);
        valid <= 1'b1;
        instr <= i;
        a <= x1;
        b <= x2;
        pv <= p1;
        am <= m1;
        exq.push_back('{ep, en, ew, ed});
        cp = ep;
        cn = en;
    endtask
    always @(posedge clk) vd <= valid & rst_n;
    always @(negedge clk) begin
        if (vd) begin
            if (exq.size() == 0) begin
                check(64'h1, 64'h0);
            end else begin
                e = exq.pop_front();
                check(pc, e.p);
                check(nx, e.n);
                check({63'h0, lwe | mwe | twe | sa | pe | fe | sr}, {63'h0, e.w});
                check(lwe ? ldat : mwe ? mdat : twe ? {55'h0, tdat} : '0, e.d);
            end
        end
    end
    initial begin
        rst_n = 1'b0; valid = 1'b0; instr = '0; a = '0; b = '0; pv = 1'b0; am = 1'b0; rt = '0;
        trap_base_register = {$random(seed), $random(seed)};
        cc = npc_ccs_t'(20'($random(seed)));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check(pc, NPC_RESET_PC);
        check(nx, NPC_RESET_NPC);
        send(mk(NPC_OP_RETRY, 0, 0, 0, 3), 0, 0, 1, 0, tps, tns, 1, 0);
        send(mk(NPC_OP_DONE, 0, 0, 0, 3), 0, 0, 1, 0, tns, tns + 4, 1, 0);
        send(mk(NPC_OP_CALL, 0, 0, 0, 3), 0, 0, 1, 1, cn, cp + 64'h40, 1, {32'h0, cp[31:0]});
        send(mk(NPC_OP_CALL, 0, 0, 0, 3), 0, 0, 1, 0, cn, cp + 64'h40, 1, cp);
        for (int k = 0; k < 4; k++) begin
            send(mk(k[1] ? NPC_OP_BCC : NPC_OP_BN, k[0], 3'h5, 0, 3), 0, 0, 1, 0,
                k[0] ? cn + 4 : cn, k[0] ? cn + 8 : cn + 4, k[0], 0);
        end
        send(mk(NPC_OP_BA, 0, 0, 0, 3), 0, 0, 1, 0, cn, cp + 64'h40, 0, 0);
        send(mk(NPC_OP_BA, 1, 0, 0, 3), 0, 0, 1, 0, cp + 64'h40, cp + 64'h44, 1, 0);
        send(mk(NPC_OP_BCC, 0, NPC_CC_XCC, 0, 3), 0, 0, 1, 0, cn, cp + 64'h40, 0, 0);
        r1 = {$random(seed), $random(seed)};
        r2 = {$random(seed), $random(seed)};
        send(mk(NPC_OP_JUMP_AND_LINK, 0, 0, 1, 3), r1, r2, 1, 0, cn, r1 - 8, 1, cp);
        send(mk(NPC_OP_JUMP_AND_LINK, 0, 0, 0, 0), r1, r2, 1, 0, cn, r1 + r2, 0, 0);
        send(mk(NPC_OP_RETURN, 0, 0, 0, 0), r1, r2, 1, 0, cp, cn, 1, 0);
        s = r1 + r2;
        for (int k = 0; k < 2; k++) begin
            tt = 9'h100 + (k == 0 ? {1'b0, s[7:0]} : {2'b0, s[6:0]});
            ea = {trap_base_register[63:15], k[0], tt, 5'h00};
            send(mk(NPC_OP_TCC, 0, NPC_CC_ICC, 0, 3), r1, r2, k == 0, 0, ea, ea + 4, 1, {55'h0, tt});
        end
        send(mk(NPC_OP_TCC, 0, 3'h5, 0, 3), r1, r2, 1, 0, cn, cn + 4, 0, 0);
        send(mk(NPC_OP_RETRY, 0, 0, 0, 3), 0, 0, 0, 0, cp, cn, 1, 0);
        for (int j = 0; j < 12; j++) begin
            rt = j % 6 + (j % 6 > 2) + 1;
            r1 = (j >= 6) ? '0 : {$random(seed), $random(seed)};
            r2 = {$random(seed), $random(seed)};
            h = rt[2] ^ ((rt[1:0] == 2'h1) ? r1 == 0 : (rt[1:0] == 2'h2) ? $signed(r1) <= 0 : $signed(r1) < 0);
            send(mk(NPC_OP_REGISTER_CONDITIONAL_MOVE, 0, 0, 0, 3), r1, r2, 1, 0, cn, cn + 4, h, h ? r2 : '0);
        end
        // always and never conditions over all six sets, whatever the codes hold
        for (int k = 0; k < 12; k++) begin
            ins = mk(NPC_OP_CC_CONDITIONAL_MOVE, 0, (k % 6 == 5) ? 3'h6 : 3'(k % 6), 0, 3);
            ins.cond = (k < 6) ? 4'h8 : 4'h0;
            send(ins, r1, r2, 1, 0, cn, cn + 4, k < 6, (k < 6) ? r2 : '0);
        end
        @(posedge clk);
        valid <= 1'b0;
        for (int k = 0; k < 8 && exq.size() != 0; k++) @(posedge clk);
        if (exq.size() != 0) n_errors++;
        finish_test();
    end
endmodule

// [verilog/npc_cond_eval.sv]
// branch condition evaluation against one of six condition-code sets
`timescale 1ns/1ps
module npc_cond_eval
    import npc_pkg::*;
(
    // selection
    input wire logic [3:0] cond_i,
    input wire logic [2:0] cc_sel_i,
    input wire npc_ccs_t ccs_i,
    // result
    output logic holds_o
);
    logic [3:0] flags;
    logic [1:0] fcc;
    logic [3:0] fmask;
    logic n, z, v, c;

    always_comb begin
        flags = (cc_sel_i == NPC_CC_XCC) ? ccs_i.xcc : ccs_i.icc;
        {n, z, v, c} = flags;
        unique case (cc_sel_i)
            NPC_CC_FLOAT_A: fcc = ccs_i.float_cc_set_a;
            NPC_CC_FLOAT_B: fcc = ccs_i.float_cc_set_b;
            NPC_CC_FLOAT_C: fcc = ccs_i.float_cc_set_c;
            default: fcc = ccs_i.float_cc_set_d;
        endcase
        // float mask bits: unordered, greater, less, equal
        unique case (cond_i)
            4'h0: fmask = 4'h0;
            4'h1: fmask = 4'hE;
            4'h2: fmask = 4'h6;
            4'h3: fmask = 4'hA;
            4'h4: fmask = 4'h2;
            4'h5: fmask = 4'hC;
            4'h6: fmask = 4'h4;
            4'h7: fmask = 4'h8;
            4'h8: fmask = 4'hF;
            4'h9: fmask = 4'h1;
            4'hA: fmask = 4'h9;
            4'hB: fmask = 4'h5;
            4'hC: fmask = 4'hD;
            4'hD: fmask = 4'h3;
            4'hE: fmask = 4'hB;
            default: fmask = 4'h7;
        endcase
        if (cc_sel_i[2] == 1'b0) begin
            holds_o = fmask[fcc];
        end else if (cc_sel_i == NPC_CC_ICC || cc_sel_i == NPC_CC_XCC) begin
            unique case (cond_i[2:0])
                3'h0: holds_o = 1'b0;
                3'h1: holds_o = z;
                3'h2: holds_o = z | (n ^ v);
                3'h3: holds_o = n ^ v;
                3'h4: holds_o = c | z;
                3'h5: holds_o = c;
                3'h6: holds_o = n;
                default: holds_o = v;
            endcase
            holds_o = holds_o ^ cond_i[3];
        end else begin
            // unused select codes never satisfy
            holds_o = 1'b0;
        end
    end
endmodule

// [verilog/npc_ctrl.sv]
// next program counter, control transfer, trap entry/return and conditional moves
`timescale 1ns/1ps
// Operation
// - taken/not-taken/annulled branch pc updates
// - annul bit governs delay slot execution
// - branch-always annulled skips slot, goes target
// - branch_never never transfers, annul skips slot
// - pc-relative target from shifted sign-extended displacement
// - register-indirect target, register or immediate
// - trap number seven or eight bits
// - taken trap increments level (held at MAXTL), writes type
// - taken trap jumps undelayed to vector
// - failed trap condition acts as nop
// - call links register 15, delayed jump
// - jump_and_link links rd, delayed jump
// - address mask zeroes upper link half
// - return jumps indirect and restores window
// - done/retry load pc from trap stacks
// - done/retry privileged, restore saved state
// - annulled slot need not be fetched
// - cc move under one of six sets
// - register move on signed register test
// - annulled slot changes nothing, never traps
// - register zero writes are discarded
// - window restore counters and fill exception
module npc_ctrl
    import npc_pkg::*;
#(
    parameter int NWIN = 8,
    parameter int MAXTL = 6
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // decoded instruction
    input wire logic valid_i,
    input wire npc_instr_t instr_i,
    input wire logic [63:0] first_source_reg_i,
    input wire logic [63:0] second_source_reg_i,
    input wire logic [63:0] move_source_i,
    // machine state from partner
    input wire npc_ccs_t ccs_i,
    input wire logic priv_i,
    input wire logic address_mask_flag_i,
    input wire logic [63:0] trap_base_register_i,
    input wire logic [63:0] trap_pc_stack_i,
    input wire logic [63:0] trap_npc_stack_i,
    input wire logic [63:0] trap_state_stack_i,
    // program counters
    output logic [63:0] pc_o,
    output logic [63:0] next_program_counter_o,
    output logic slot_annulled_o,
    // register writes
    output logic link_we_o,
    output logic [4:0] link_idx_o,
    output logic [63:0] link_data_o,
    output logic move_we_o,
    output logic [4:0] move_idx_o,
    output logic [63:0] move_data_o,
    // trap state
    output logic [NPC_TL_W-1:0] trap_level_o,
    output logic trap_type_we_o,
    output logic [NPC_TL_W-1:0] trap_type_idx_o,
    output logic [8:0] trap_type_data_o,
    output logic state_restore_o,
    output logic [63:0] restored_state_o,
    output logic priv_exc_o,
    // register windows
    output logic [NPC_WIN_W-1:0] current_window_pointer_o,
    output logic [NPC_WIN_W-1:0] restorable_window_count_o,
    output logic [NPC_WIN_W-1:0] savable_window_count_o,
    output logic fill_exc_o
);
    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic [63:0] pc;
        logic [63:0] npc;
        logic annul;
        logic link_we;
        logic [4:0] link_idx;
        logic [63:0] link_data;
        logic move_we;
        logic [4:0] move_idx;
        logic [63:0] move_data;
        logic [NPC_TL_W-1:0] tl;
        logic tt_we;
        logic [NPC_TL_W-1:0] tt_idx;
        logic [8:0] tt_data;
        logic restore;
        logic [63:0] trap_state_stack;
        logic priv_exc;
        logic [NPC_WIN_W-1:0] current_window_pointer;
        logic [NPC_WIN_W-1:0] restorable_window_count;
        logic [NPC_WIN_W-1:0] savable_window_count;
        logic fill_exc;
    } npc_state_t;

    localparam logic [NPC_WIN_W-1:0] RESET_SAVABLE_WINDOW_COUNT = NPC_WIN_W'(NWIN - 2);
    localparam logic [NPC_TL_W-1:0] TL_MAX = NPC_TL_W'(MAXTL);

    npc_state_t st, next_st;
    logic cc_holds, reg_holds;
    logic [63:0] imm_ext, operand2, ea_pc, ea_reg, ea_trap, link_val;
    logic [7:0] trap_num;
    logic [8:0] trap_type;
    logic fill_fault;

    npc_cond_eval u_cond (
        .cond_i(instr_i.cond),
        .cc_sel_i(instr_i.cc_sel),
        .ccs_i(ccs_i),
        .holds_o(cc_holds)
    );

    npc_reg_test u_rtest (
        .rtest_i(instr_i.rtest),
        .value_i(first_source_reg_i),
        .holds_o(reg_holds)
    );

    // ********************************
    // address generation
    // ********************************
    always_comb begin
        imm_ext = {{51{instr_i.signed_imm_13[12]}}, instr_i.signed_imm_13};
        operand2 = instr_i.imm_sel ? imm_ext : second_source_reg_i;
        // carries past bit 63 fall off by width
        ea_pc = st.pc + {{32{instr_i.disp[29]}}, instr_i.disp, 2'b00};
        ea_reg = first_source_reg_i + operand2;
        trap_num = ea_reg[7:0] & (priv_i ? NPC_TRAP_MASK_PRIV : NPC_TRAP_MASK_USER);
        trap_type = NPC_TT_SW_BASE + {1'b0, trap_num};
        ea_trap = {trap_base_register_i[63:NPC_TBA_LSB], st.tl != NPC_RESET_TL,
                   trap_type, 5'h00};
        // upper half zeroed while masking addresses
        link_val = address_mask_flag_i ? {32'h0, st.pc[31:0]} : st.pc;
        fill_fault = (st.restorable_window_count == NPC_RESET_RESTORABLE_WINDOW_COUNT);
    end

    // ********************************
    // next state
    // ********************************
    always_comb begin
        next_st = st;
        next_st.annul = 1'b0;
        next_st.link_we = 1'b0;
        next_st.move_we = 1'b0;
        next_st.tt_we = 1'b0;
        next_st.restore = 1'b0;
        next_st.priv_exc = 1'b0;
        next_st.fill_exc = 1'b0;
        if (valid_i) begin
            next_st.pc = st.npc;
            next_st.npc = st.npc + NPC_STEP;
            unique case (instr_i.op)
                NPC_OP_BCC: begin
                    if (cc_holds) begin
                        next_st.npc = ea_pc;
                    end else if (instr_i.annul) begin
                        // slot skipped outright, so it is never fetched
                        next_st.pc = st.npc + NPC_STEP;
                        next_st.npc = st.npc + NPC_SKIP;
                        next_st.annul = 1'b1;
                    end
                end
                NPC_OP_BA: begin
                    if (instr_i.annul) begin
                        next_st.pc = ea_pc;
                        next_st.npc = ea_pc + NPC_STEP;
                        next_st.annul = 1'b1;
                    end else begin
                        next_st.npc = ea_pc;
                    end
                end
                NPC_OP_BN: begin
                    if (instr_i.annul) begin
                        next_st.pc = st.npc + NPC_STEP;
                        next_st.npc = st.npc + NPC_SKIP;
                        next_st.annul = 1'b1;
                    end
                end
                NPC_OP_CALL: begin
                    next_st.npc = ea_pc;
                    next_st.link_we = 1'b1;
                    next_st.link_idx = NPC_LINK_REG;
                    next_st.link_data = link_val;
                end
                NPC_OP_JUMP_AND_LINK: begin
                    next_st.npc = ea_reg;
                    next_st.link_we = (instr_i.rd != NPC_ZERO_REG);
                    next_st.link_idx = instr_i.rd;
                    next_st.link_data = link_val;
                end
                NPC_OP_RETURN: begin
                    if (fill_fault) begin
                        // exception: no transfer, windows untouched
                        next_st.pc = st.pc;
                        next_st.npc = st.npc;
                        next_st.fill_exc = 1'b1;
                    end else begin
                        // destination is register zero, so no link write
                        next_st.npc = ea_reg;
                        next_st.current_window_pointer = st.current_window_pointer - 1'b1;
                        next_st.restorable_window_count = st.restorable_window_count - 1'b1;
                        next_st.savable_window_count = st.savable_window_count + 1'b1;
                    end
                end
                NPC_OP_DONE, NPC_OP_RETRY: begin
                    if (!priv_i) begin
                        next_st.pc = st.pc;
                        next_st.npc = st.npc;
                        next_st.priv_exc = 1'b1;
                    end else begin
                        if (instr_i.op == NPC_OP_DONE) begin
                            next_st.pc = trap_npc_stack_i;
                            next_st.npc = trap_npc_stack_i + NPC_STEP;
                        end else begin
                            next_st.pc = trap_pc_stack_i;
                            next_st.npc = trap_npc_stack_i;
                        end
                        next_st.restore = 1'b1;
                        next_st.trap_state_stack = trap_state_stack_i;
                        if (st.tl != NPC_RESET_TL) begin
                            next_st.tl = st.tl - 1'b1;
                        end
                    end
                end
                NPC_OP_TCC: begin
                    // no match leaves the sequential default
                    if (cc_holds) begin
                        next_st.pc = ea_trap;
                        next_st.npc = ea_trap + NPC_STEP;
                        if (st.tl != TL_MAX) begin
                            next_st.tl = st.tl + 1'b1;
                        end
                        next_st.tt_we = 1'b1;
                        next_st.tt_idx = next_st.tl;
                        next_st.tt_data = trap_type;
                    end
                end
                NPC_OP_CC_CONDITIONAL_MOVE: begin
                    // a failed test writes nothing; codes are never touched
                    next_st.move_we = cc_holds && instr_i.rd != NPC_ZERO_REG;
                    next_st.move_idx = instr_i.rd;
                    next_st.move_data = move_source_i;
                end
                NPC_OP_REGISTER_CONDITIONAL_MOVE: begin
                    next_st.move_we = reg_holds && instr_i.rd != NPC_ZERO_REG;
                    next_st.move_idx = instr_i.rd;
                    next_st.move_data = move_source_i;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.pc <= NPC_RESET_PC;
            st.npc <= NPC_RESET_NPC;
            st.tl <= NPC_RESET_TL;
            st.current_window_pointer <= NPC_RESET_CWP;
            st.restorable_window_count <= NPC_RESET_RESTORABLE_WINDOW_COUNT;
            st.savable_window_count <= RESET_SAVABLE_WINDOW_COUNT;
        end else begin
            st <= next_st;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign pc_o = st.pc;
    assign next_program_counter_o = st.npc;
    assign slot_annulled_o = st.annul;
    assign link_we_o = st.link_we;
    assign link_idx_o = st.link_idx;
    assign link_data_o = st.link_data;
    assign move_we_o = st.move_we;
    assign move_idx_o = st.move_idx;
    assign move_data_o = st.move_data;
    assign trap_level_o = st.tl;
    assign trap_type_we_o = st.tt_we;
    assign trap_type_idx_o = st.tt_idx;
    assign trap_type_data_o = st.tt_data;
    assign state_restore_o = st.restore;
    assign restored_state_o = st.trap_state_stack;
    assign priv_exc_o = st.priv_exc;
    assign current_window_pointer_o = st.current_window_pointer;
    assign restorable_window_count_o = st.restorable_window_count;
    assign savable_window_count_o = st.savable_window_count;
    assign fill_exc_o = st.fill_exc;

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic go_bcc, go_tcc;
    assign go_bcc = valid_i && instr_i.op == NPC_OP_BCC;
    assign go_tcc = valid_i && instr_i.op == NPC_OP_TCC;

    a_bcc_taken: assert property (go_bcc && cc_holds |=>
        pc_o == $past(st.npc) && next_program_counter_o == $past(ea_pc))
        else $error("taken branch target wrong");
    a_bcc_annul: assert property (go_bcc && !cc_holds && instr_i.annul |=>
        slot_annulled_o && pc_o == $past(st.npc) + NPC_STEP)
        else $error("annulled branch did not skip slot");
    a_ba_annul: assert property (valid_i && instr_i.op == NPC_OP_BA && instr_i.annul |=>
        pc_o == $past(ea_pc) && next_program_counter_o == $past(ea_pc) + NPC_STEP)
        else $error("annulled branch-always wrong");
    a_bn_plain: assert property (valid_i && instr_i.op == NPC_OP_BN && !instr_i.annul |=>
        !slot_annulled_o && next_program_counter_o == pc_o + NPC_STEP)
        else $error("branch_never transferred");
    a_call_link: assert property (valid_i && instr_i.op == NPC_OP_CALL |=>
        link_we_o && link_idx_o == NPC_LINK_REG && link_data_o[31:0] == $past(st.pc[31:0]))
        else $error("call link missing");
    a_link_mask: assert property (link_we_o && $past(address_mask_flag_i) |->
        link_data_o[63:32] == 32'h0)
        else $error("link upper half not masked");
    a_zero_nowrite: assert property (link_we_o || move_we_o |->
        (!link_we_o || link_idx_o != NPC_ZERO_REG) && (!move_we_o || move_idx_o != NPC_ZERO_REG))
        else $error("write to register zero");
    a_tcc_type: assert property (go_tcc && cc_holds && st.tl != TL_MAX |=>
        trap_type_we_o && trap_level_o == $past(st.tl) + 1'b1 && trap_type_idx_o == trap_level_o
        && trap_type_data_o[8] && next_program_counter_o == pc_o + NPC_STEP)
        else $error("trap entry wrong");
    a_tcc_user: assert property (go_tcc && cc_holds && !priv_i |=> !trap_type_data_o[7])
        else $error("user trap number over seven bits");
    a_tcc_nop: assert property (go_tcc && !cc_holds |=> !trap_type_we_o &&
        $stable(trap_level_o) && pc_o == $past(st.npc))
        else $error("failed trap changed state");
    a_done_npc: assert property (valid_i && instr_i.op == NPC_OP_DONE && priv_i |=>
        state_restore_o && next_program_counter_o == $past(trap_npc_stack_i) + NPC_STEP)
        else $error("done target wrong");
    a_retry_priv: assert property (valid_i && instr_i.op == NPC_OP_RETRY && !priv_i |=>
        priv_exc_o && !state_restore_o && $stable(pc_o))
        else $error("user retry not refused");
    a_fill_exc: assert property (valid_i && instr_i.op == NPC_OP_RETURN && fill_fault |=>
        fill_exc_o && $stable(current_window_pointer_o) && $stable(savable_window_count_o))
        else $error("fill exception missing");
    a_register_conditional_move_fail: assert property (valid_i && instr_i.op == NPC_OP_REGISTER_CONDITIONAL_MOVE && !reg_holds |=>
        !move_we_o)
        else $error("failed move wrote");

    c_bcc_annul: cover property (go_bcc && !cc_holds && instr_i.annul);
    c_tcc_taken: cover property (go_tcc && cc_holds ##1 trap_type_we_o);
    c_retry: cover property (valid_i && instr_i.op == NPC_OP_RETRY && priv_i);
    c_return_ok: cover property (valid_i && instr_i.op == NPC_OP_RETURN && !fill_fault);
endmodule

// [verilog/npc_pkg.sv]
// constants and carrier types for the next pc and conditional move block
package npc_pkg;
    // ********************************
    // instruction classes
    // ********************************
    typedef enum logic [3:0] {
        NPC_OP_PLAIN  = 4'h0,
        NPC_OP_BCC    = 4'h1,
        NPC_OP_BA     = 4'h2,
        NPC_OP_BN     = 4'h3,
        NPC_OP_CALL   = 4'h4,
        NPC_OP_JUMP_AND_LINK   = 4'h5,
        NPC_OP_RETURN = 4'h6,
        NPC_OP_DONE   = 4'h7,
        NPC_OP_RETRY  = 4'h8,
        NPC_OP_TCC    = 4'h9,
        NPC_OP_CC_CONDITIONAL_MOVE  = 4'hA,
        NPC_OP_REGISTER_CONDITIONAL_MOVE   = 4'hB
    } npc_op_t;

    // ********************************
    // constants
    // ********************************
    localparam logic [63:0] NPC_STEP = 64'h0000_0000_0000_0004;
    localparam logic [63:0] NPC_SKIP = 64'h0000_0000_0000_0008;
    localparam logic [63:0] NPC_RESET_PC = 64'h0000_0000_0000_0000;
    localparam logic [63:0] NPC_RESET_NPC = 64'h0000_0000_0000_0004;
    localparam logic [8:0] NPC_TT_SW_BASE = 9'h100;
    localparam logic [7:0] NPC_TRAP_MASK_USER = 8'h7F;
    localparam logic [7:0] NPC_TRAP_MASK_PRIV = 8'hFF;
    localparam logic [4:0] NPC_LINK_REG = 5'h0F;
    localparam logic [4:0] NPC_ZERO_REG = 5'h00;
    localparam int NPC_TBA_LSB = 15;
    localparam int NPC_TL_W = 3;
    localparam int NPC_WIN_W = 3;
    localparam logic [NPC_TL_W-1:0] NPC_RESET_TL = 3'h0;
    localparam logic [NPC_WIN_W-1:0] NPC_RESET_CWP = 3'h0;
    localparam logic [NPC_WIN_W-1:0] NPC_RESET_RESTORABLE_WINDOW_COUNT = 3'h0;
    // condition-code set selects: four float sets, then the two integer sets
    localparam logic [2:0] NPC_CC_FLOAT_A = 3'h0;
    localparam logic [2:0] NPC_CC_FLOAT_B = 3'h1;
    localparam logic [2:0] NPC_CC_FLOAT_C = 3'h2;
    localparam logic [2:0] NPC_CC_FLOAT_D = 3'h3;
    localparam logic [2:0] NPC_CC_ICC = 3'h4;
    localparam logic [2:0] NPC_CC_XCC = 3'h6;
    // register tests
    localparam logic [2:0] NPC_TEST_ZERO = 3'h1;
    localparam logic [2:0] NPC_TEST_AT_MOST_ZERO = 3'h2;
    localparam logic [2:0] NPC_TEST_BELOW_ZERO = 3'h3;
    localparam logic [2:0] NPC_TEST_NONZERO = 3'h5;
    localparam logic [2:0] NPC_TEST_ABOVE_ZERO = 3'h6;
    localparam logic [2:0] NPC_TEST_AT_LEAST_ZERO = 3'h7;

    // ********************************
    // carriers
    // ********************************
    typedef struct packed {
        npc_op_t op;
        logic annul;
        logic [3:0] cond;
        logic [2:0] cc_sel;
        logic [2:0] rtest;
        logic imm_sel;
        logic [29:0] disp;
        logic [12:0] signed_imm_13;
        logic [4:0] rd;
    } npc_instr_t;

    typedef struct packed {
        logic [3:0] icc;
        logic [3:0] xcc;
        logic [1:0] float_cc_set_a;
        logic [1:0] float_cc_set_b;
        logic [1:0] float_cc_set_c;
        logic [1:0] float_cc_set_d;
    } npc_ccs_t;
endpackage

// [verilog/npc_reg_test.sv]
// signed register test for register-conditional moves
`timescale 1ns/1ps
module npc_reg_test
    import npc_pkg::*;
(
    // selection
    input wire logic [2:0] rtest_i,
    input wire logic [63:0] value_i,
    // result
    output logic holds_o
);
    logic zero, neg;

    always_comb begin
        zero = (value_i == 64'h0);
        neg = value_i[63];
        unique case (rtest_i)
            NPC_TEST_ZERO: holds_o = zero;
            NPC_TEST_AT_MOST_ZERO: holds_o = zero | neg;
            NPC_TEST_BELOW_ZERO: holds_o = neg;
            NPC_TEST_NONZERO: holds_o = !zero;
            NPC_TEST_ABOVE_ZERO: holds_o = !zero & !neg;
            NPC_TEST_AT_LEAST_ZERO: holds_o = !neg;
            default: holds_o = 1'b0;
        endcase
    end
endmodule
